// ===== rtl/hcis_top.sv
// Purpose: Interrupt status logic of the B and D channel HDLC controllers
// Assumes: Events are one-cycle pulses from logic on clock_i; reads are strobes
// Notes:   Status words are read-to-clear; int_request_n_o is active low
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - B transmit pool ready raised when a 64-byte pool empties, also after reset cmd.
// - During an open B frame without end of message, pool ready repeats per pool.
// - After end of message, pool ready waits until checksum and closing flag left.
// - B message repeat flag set when last frame must be resent.
// - B underrun flag set on empty FIFO during an open frame with no end-of-message command.
// - Reading D status clears all unmasked bits except command-indicate change and extended indication.
// - Reading D extended status clears it and the extended indication.
// - Masked D status bits other than command-indicate change and extended indication are hidden, stay pending, and reads do not clear them.
// - Masked extended indication is neither set nor drives the interrupt.
// - Command-indicate change sets even when masked, but then no interrupt.
// - D channel has receive and transmit FIFOs of two 32-byte pools.
// - D receive pool full raised at 32 octets of unfinished frame.
// - D receive message end raised at frame end, with 5-bit byte count.
// - D receive overflow set when a whole frame is lost for lack of space.
// - Protocol error set in automatic mode on bad sequence number or S frame with data.
// - D transmit pool ready on free space, or on acknowledgement in automatic mode.
// - D message repeat set on transmit error or, in automatic mode, peer negative acknowledge.
// - D underrun set when FIFO empties before end of message.
// - Peer status change raised in automatic mode on RR or RNR frame.
// - Primary timer flag on external timer or, in automatic mode, both retransmission timer and retry expiry.
// - Second timer flag on each expiry of timer two, no acknowledge needed.
// - Interrupt request held low until every unmasked source is read clear.
module hcis_top #(
  parameter int unsigned NUM_BCH   = 2,
  parameter int unsigned POOL_D    = hcis_pkg::DCH_POOL_BYTES,
  parameter int unsigned POOL_B    = hcis_pkg::BCH_POOL_BYTES
) (
  input  wire logic                          clock_i,
  input  wire logic                          reset_i,
  input  wire hcis_pkg::hcis_bev_s [NUM_BCH-1:0] bch_ev_i,
  input  wire hcis_pkg::hcis_dev_s           dch_ev_i,
  input  wire hcis_pkg::hcis_rd_s  [NUM_BCH-1:0] bch_rd_i,
  input  wire hcis_pkg::hcis_rd_s            dch_rd_i,
  input  wire logic                          auto_mode_i,
  input  wire logic [hcis_pkg::DST_W-1:0]    dchan_mask_reg_i,
  input  wire logic                          ext_ind_mask_i,
  input  wire logic [NUM_BCH-1:0]            bch_mask_i,
  output logic [NUM_BCH-1:0]                 bch_pool_ready_o,
  output logic [2*NUM_BCH-1:0]               bch_ext_o,
  output logic [hcis_pkg::DST_W-1:0]         dchan_status_reg_o,
  output logic [hcis_pkg::DEX_W-1:0]         dchan_extended_status_reg_o,
  output logic [hcis_pkg::RBC_W-1:0]         receive_byte_count_field_o,
  output logic                               dchan_extended_indication_o,
  output logic [hcis_pkg::DST_W-1:0]         dchan_pending_o,
  output logic                               int_request_n_o
);

  // Two pools per FIFO direction; depth fixed by the pool size
  localparam int unsigned DFIFO_BYTES = hcis_pkg::POOLS * POOL_D;

  logic [hcis_pkg::DST_W-1:0] dst_q, dst_d, dst_set;
  logic [hcis_pkg::DEX_W-1:0] dex_q, dex_d, dex_set;
  logic                       exi_q, exi_d;
  logic [hcis_pkg::RBC_W-1:0] rbc_q, rbc_d;
  logic [hcis_pkg::DST_W-1:0] visible;
  logic [NUM_BCH-1:0]         bch_any;
  logic                       d_int;

  // B channel transmitters
  genvar g;
  generate
    for (g = 0; g < NUM_BCH; g++) begin : g_bch
      logic [1:0] ext_w;
      hcis_bchan_tx u_btx (
        .clock_i      (clock_i),
        .reset_i      (reset_i),
        .ev_i         (bch_ev_i[g]),
        .rd_status_i  (bch_rd_i[g].rd_bst),
        .rd_ext_i     (bch_rd_i[g].rd_bex),
        .pool_ready_o (bch_pool_ready_o[g]),
        .ext_o        (ext_w)
      );
      assign bch_ext_o[2*g+1:2*g] = ext_w;
      assign bch_any[g] = ~bch_mask_i[g] & (bch_pool_ready_o[g] | (|ext_w));
    end
  endgenerate

  // Event decode for the D channel
  always_comb begin
    dst_set = '0;
    dex_set = '0;
    dst_set[hcis_pkg::DST_RPF]  = dch_ev_i.rx_pool_full;
    dst_set[hcis_pkg::DST_RME]  = dch_ev_i.rx_msg_end;
    dst_set[hcis_pkg::DST_RSC]  = auto_mode_i & dch_ev_i.rx_rr_rnr;
    dst_set[hcis_pkg::DST_XPR]  = dch_ev_i.tx_pool_freed
                                | (auto_mode_i & dch_ev_i.tx_acked);
    dst_set[hcis_pkg::DST_TIN]  = dch_ev_i.ext_timer
                                | (auto_mode_i & dch_ev_i.retransmission_timer_out
                                   & dch_ev_i.retry_counter_out);
    dst_set[hcis_pkg::DST_SECOND_TIMER_FLAG] = dch_ev_i.timer2;
    dst_set[hcis_pkg::DST_CIC]  = dch_ev_i.ci_change;
    dex_set[hcis_pkg::DEX_RFO]  = dch_ev_i.rx_frame_lost;
    dex_set[hcis_pkg::DEX_PCE]  = auto_mode_i
                                & (dch_ev_i.rx_bad_nr | dch_ev_i.rx_s_with_i);
    dex_set[hcis_pkg::DEX_XMR]  = dch_ev_i.tx_error
                                | (auto_mode_i & dch_ev_i.tx_nak);
    dex_set[hcis_pkg::DEX_XDU]  = dch_ev_i.tx_fifo_empty
                                & ~dch_ev_i.tx_eom_given;
  end

  // Read-clear and masking
  always_comb begin
    logic [hcis_pkg::DST_W-1:0] clr;
    clr = '0;
    if (dch_rd_i.rd_dst) begin
      // Only unmasked bits clear; masked ones stay pending
      clr = ~dchan_mask_reg_i;
      clr[hcis_pkg::DST_CIC] = 1'b0;
      clr[hcis_pkg::DST_EXI] = 1'b0;
    end
    if (dch_rd_i.rd_ci) begin
      clr[hcis_pkg::DST_CIC] = 1'b1;
    end
    dst_d = dst_set | (dst_q & ~clr);
    dex_d = dex_set | (dex_q & ~{hcis_pkg::DEX_W{dch_rd_i.rd_dex}});
    // Indication follows pending extended bits unless masked at top level
    exi_d = ~ext_ind_mask_i & ((|dex_set) | (exi_q & ~dch_rd_i.rd_dex));
    rbc_d = dch_ev_i.rx_msg_end ? dch_ev_i.rx_count : rbc_q;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      dst_q <= hcis_pkg::DST_RESET;
      dex_q <= hcis_pkg::DEX_RESET;
      exi_q <= 1'b0;
      rbc_q <= '0;
    end else begin
      dst_q <= dst_d;
      dex_q <= dex_d;
      exi_q <= exi_d;
      rbc_q <= rbc_d;
    end
  end

  // Status word as seen by a read: masked bits hidden except the CI change and the extended indication
  always_comb begin
    visible = dst_q & ~dchan_mask_reg_i;
    visible[hcis_pkg::DST_CIC] = dst_q[hcis_pkg::DST_CIC];
    visible[hcis_pkg::DST_EXI] = exi_q;
  end

  // CI change shows but does not interrupt while masked
  assign d_int = |(dst_q & ~dchan_mask_reg_i) | exi_q;

  assign dchan_status_reg_o          = visible;
  assign dchan_extended_status_reg_o = dex_q;
  assign receive_byte_count_field_o  = rbc_q;
  assign dchan_extended_indication_o = exi_q;
  assign dchan_pending_o             = dst_q;
  assign int_request_n_o             = ~(d_int | (|bch_any));

  AST_D_SET_LAT: assert property (@(posedge clock_i) disable iff (reset_i)
    dch_ev_i.rx_pool_full |=> dst_q[hcis_pkg::DST_RPF])
    else $error("pool full not set one cycle later");
  AST_D_RME_CNT: assert property (@(posedge clock_i) disable iff (reset_i)
    dch_ev_i.rx_msg_end |=> (dst_q[hcis_pkg::DST_RME]
      && rbc_q == $past(dch_ev_i.rx_count)))
    else $error("message end or count wrong");
  AST_D_RD_CLR: assert property (@(posedge clock_i) disable iff (reset_i)
    (dch_rd_i.rd_dst && !dchan_mask_reg_i[hcis_pkg::DST_RPF]
      && !dch_ev_i.rx_pool_full) |=> !dst_q[hcis_pkg::DST_RPF])
    else $error("read did not clear");
  AST_D_CIC_KEEP: assert property (@(posedge clock_i) disable iff (reset_i)
    (dst_q[hcis_pkg::DST_CIC] && dch_rd_i.rd_dst && !dch_rd_i.rd_ci)
      |=> dst_q[hcis_pkg::DST_CIC])
    else $error("CI change cleared by status read");
  AST_D_MASK_KEEP: assert property (@(posedge clock_i) disable iff (reset_i)
    (dst_q[hcis_pkg::DST_RME] && dchan_mask_reg_i[hcis_pkg::DST_RME]
      && dch_rd_i.rd_dst) |=> dst_q[hcis_pkg::DST_RME])
    else $error("masked pending bit lost");
  AST_D_EXI_MASK: assert property (@(posedge clock_i) disable iff (reset_i)
    ext_ind_mask_i |=> !exi_q) else $error("masked indication set");
  AST_D_EXD_CLR: assert property (@(posedge clock_i) disable iff (reset_i)
    (dch_rd_i.rd_dex && !(|dex_set)) |=> (dex_q == '0 && !exi_q))
    else $error("extended read did not clear");
  AST_D_PCE_AUTO: assert property (@(posedge clock_i) disable iff (reset_i)
    (!auto_mode_i && !dex_q[hcis_pkg::DEX_PCE]) |=> !dex_q[hcis_pkg::DEX_PCE])
    else $error("protocol error outside auto mode");
  AST_D_CIC_NOINT: assert property (@(posedge clock_i) disable iff (reset_i)
    (dst_q == (8'h01 << hcis_pkg::DST_CIC) && dchan_mask_reg_i[hcis_pkg::DST_CIC]
      && !exi_q && !(|bch_any)) |-> int_request_n_o)
    else $error("masked CI change interrupts");
  AST_INT_LOW: assert property (@(posedge clock_i) disable iff (reset_i)
    (|(dst_q & ~dchan_mask_reg_i)) |-> !int_request_n_o)
    else $error("interrupt not asserted");

  COV_RPF: cover property (@(posedge clock_i) disable iff (reset_i)
    dch_ev_i.rx_pool_full ##1 dch_rd_i.rd_dst);
  COV_EXD: cover property (@(posedge clock_i) disable iff (reset_i)
    exi_q ##1 dch_rd_i.rd_dex ##1 !exi_q);
  COV_MASKED: cover property (@(posedge clock_i) disable iff (reset_i)
    dst_q[hcis_pkg::DST_XPR] && dchan_mask_reg_i[hcis_pkg::DST_XPR] && dch_rd_i.rd_dst);
  COV_BXPR: cover property (@(posedge clock_i) disable iff (reset_i)
    bch_pool_ready_o[0] && !int_request_n_o);

endmodule
`default_nettype wire

// ===== rtl/hcis_pkg.sv
// Purpose: Shared constants and carriers for the channel interrupt status block
// Assumes: Single clock, synchronous active-high reset
// Notes:   Bit positions of the status words, FIFO geometry and timing counts
package hcis_pkg;

  // B-channel status positions
  localparam int unsigned BST_XPR_BIT  = 0;
  localparam int unsigned BEX_XMR_BIT  = 0;
  localparam int unsigned BEX_XDU_BIT  = 1;

  // D-channel status word positions
  localparam int unsigned DST_W        = 8;
  localparam int unsigned DST_RME      = 7;
  localparam int unsigned DST_RPF      = 6;
  localparam int unsigned DST_RSC      = 5;
  localparam int unsigned DST_XPR      = 4;
  localparam int unsigned DST_TIN      = 3;
  localparam int unsigned DST_CIC      = 2;
  localparam int unsigned DST_EXI      = 1;
  localparam int unsigned DST_SECOND_TIMER_FLAG     = 0;

  // D-channel extended status word positions
  localparam int unsigned DEX_W        = 4;
  localparam int unsigned DEX_XMR      = 3;
  localparam int unsigned DEX_XDU      = 2;
  localparam int unsigned DEX_PCE      = 1;
  localparam int unsigned DEX_RFO      = 0;

  localparam logic [DST_W-1:0] DST_RESET = 8'h00;
  localparam logic [DEX_W-1:0] DEX_RESET = 4'h0;

  // FIFO geometry
  localparam int unsigned BCH_POOL_BYTES = 64;
  localparam int unsigned DCH_POOL_BYTES = 32;
  localparam int unsigned POOLS          = 2;
  localparam int unsigned RBC_W          = 5;

  // Flag set latency after the event, in cycles
  localparam int unsigned SET_LATENCY    = 1;

  // Events of one B-channel transmitter
  typedef struct packed {
    logic transmitter_reset_cmd;        // transmitter reset command
    logic transparent_transmit_cmd;         // transparent transmit command
    logic end_of_message_cmd;         // end of message command
    logic pool_freed;  // a 64-byte pool became empty
    logic fcs_done;    // closing flag shifted out
    logic repeat_req;  // last frame must be resent
    logic fifo_empty;  // all data shifted onto serial output
  } hcis_bev_s;

  // Events of the D-channel controller
  typedef struct packed {
    logic rx_pool_full;
    logic rx_msg_end;
    logic [RBC_W-1:0] rx_count;
    logic rx_frame_lost;
    logic rx_bad_nr;
    logic rx_s_with_i;
    logic rx_rr_rnr;
    logic tx_pool_freed;
    logic tx_acked;
    logic tx_error;
    logic tx_nak;
    logic tx_fifo_empty;
    logic tx_eom_given;
    logic ext_timer;
    logic retransmission_timer_out;
    logic retry_counter_out;
    logic timer2;
    logic ci_change;
  } hcis_dev_s;

  // Host read strobes
  typedef struct packed {
    logic rd_dst;
    logic rd_dex;
    logic rd_ci;
    logic rd_bst;
    logic rd_bex;
  } hcis_rd_s;

endpackage

// ===== rtl/hcis_bchan_tx.sv
// Purpose: Transmit interrupt flags of one B-channel controller
// Assumes: Event inputs are one-cycle pulses on clock_i
// Notes:   Flags are read-to-clear, a set in the clear cycle wins
`timescale 1ns/10ps
`default_nettype none
module hcis_bchan_tx (
  input  wire logic              clock_i,
  input  wire logic              reset_i,
  input  wire hcis_pkg::hcis_bev_s ev_i,
  input  wire logic              rd_status_i,
  input  wire logic              rd_ext_i,
  output logic                   pool_ready_o,
  output logic [1:0]             ext_o
);

  typedef enum logic [1:0] {
    HCIS_B_IDLE = 2'b00,
    HCIS_B_OPEN = 2'b01,
    HCIS_B_TAIL = 2'b10
  } hcis_bstate_e;

  hcis_bstate_e st_q, st_d;
  logic         xpr_q, xpr_d;
  logic         xmr_q, xmr_d;
  logic         xdu_q, xdu_d;
  logic         xpr_set;

  always_comb begin
    st_d    = st_q;
    xpr_set = 1'b0;
    if (ev_i.transmitter_reset_cmd) begin
      st_d    = HCIS_B_IDLE;
      xpr_set = 1'b1;
    end else begin
      case (st_q)
        HCIS_B_IDLE: begin
          if (ev_i.transparent_transmit_cmd) begin
            st_d = ev_i.end_of_message_cmd ? HCIS_B_TAIL : HCIS_B_OPEN;
          end
        end
        HCIS_B_OPEN: begin
          xpr_set = ev_i.pool_freed;
          if (ev_i.end_of_message_cmd) begin
            st_d = HCIS_B_TAIL;
          end
        end
        HCIS_B_TAIL: begin
          if (ev_i.fcs_done) begin
            st_d    = HCIS_B_IDLE;
            xpr_set = 1'b1;
          end
        end
        default: st_d = HCIS_B_IDLE;
      endcase
    end
    // Set before clear: an event in the read cycle survives
    xpr_d = xpr_set | (xpr_q & ~rd_status_i);
    xmr_d = ev_i.repeat_req | (xmr_q & ~rd_ext_i);
    xdu_d = (ev_i.fifo_empty & (st_q == HCIS_B_OPEN) & ~ev_i.end_of_message_cmd)
          | (xdu_q & ~rd_ext_i);
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_q  <= HCIS_B_IDLE;
      xpr_q <= 1'b0;
      xmr_q <= 1'b0;
      xdu_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      xpr_q <= xpr_d;
      xmr_q <= xmr_d;
      xdu_q <= xdu_d;
    end
  end

  assign pool_ready_o = xpr_q;
  assign ext_o        = {xdu_q, xmr_q};

  AST_B_TRANSMITTER_RESET_CMD_XPR: assert property (@(posedge clock_i) disable iff (reset_i)
    ev_i.transmitter_reset_cmd |=> xpr_q) else $error("pool ready missing after reset cmd");
  AST_B_XDU: assert property (@(posedge clock_i) disable iff (reset_i)
    (ev_i.fifo_empty && st_q == HCIS_B_OPEN && !ev_i.end_of_message_cmd && !ev_i.transmitter_reset_cmd) |=> xdu_q)
    else $error("underrun flag not set");
  AST_B_XMR: assert property (@(posedge clock_i) disable iff (reset_i)
    ev_i.repeat_req |=> xmr_q) else $error("repeat flag not set");

endmodule
`default_nettype wire

// ===== test/hcis_host_model.sv
// Purpose: Host that services the D-channel interrupt by reading status
// Assumes: Strobes change at the falling edge, one cycle long
// Notes:   Leaves one idle cycle after each read so cleared flags settle
`timescale 1ns/10ps
`default_nettype none
module hcis_host_model (
  input  wire logic                       clock_i,
  input  wire logic                       en_i,
  input  wire logic                       int_n_i,
  input  wire logic                       ext_i,
  input  wire logic [hcis_pkg::DST_W-1:0] status_i,
  output var hcis_pkg::hcis_rd_s          rd_o
);
  // Single driver; en_i is low during reset so rd_o settles to zero first
  always @(negedge clock_i) begin
    rd_o <= '0;
    if (en_i && !int_n_i && rd_o == '0) begin
      rd_o.rd_dst <= 1'b1;
      rd_o.rd_dex <= ext_i;
      rd_o.rd_ci  <= status_i[hcis_pkg::DST_CIC];
    end
  end
endmodule
`default_nettype wire

// ===== test/test_hdlc_channel_interrupt_status.sv
// Purpose: Self-checking bench of the channel interrupt status block
// Assumes: Inputs driven at the falling edge, flags seen one cycle later
// Notes:   A host model takes over the D reads in the last test
`timescale 1ns/10ps
`default_nettype none
module test_hdlc_channel_interrupt_status;
  logic                      clock_i, reset_i, auto_m, ext_m, host_en;
  hcis_pkg::hcis_bev_s [1:0] bev;
  hcis_pkg::hcis_dev_s       dev;
  hcis_pkg::hcis_rd_s  [1:0] brd;
  hcis_pkg::hcis_rd_s        drd, hrd;
  logic [7:0]                mask, st, pend;
  logic [1:0]                bmask, bpr;
  logic [3:0]                bext, dex;
  logic [4:0]                rbc;
  logic                      ext_ind, int_n;
  int                        err_count, n_checks;

  hcis_top hcis_top_i (.clock_i(clock_i), .reset_i(reset_i), .bch_ev_i(bev),
    .dch_ev_i(dev), .bch_rd_i(brd), .dch_rd_i(drd | hrd), .auto_mode_i(auto_m),
    .dchan_mask_reg_i(mask), .ext_ind_mask_i(ext_m), .bch_mask_i(bmask),
    .bch_pool_ready_o(bpr), .bch_ext_o(bext), .dchan_status_reg_o(st),
    .dchan_extended_status_reg_o(dex), .receive_byte_count_field_o(rbc),
    .dchan_extended_indication_o(ext_ind), .dchan_pending_o(pend),
    .int_request_n_o(int_n));
  hcis_host_model hcis_host_model_i (.clock_i(clock_i), .en_i(host_en),
    .int_n_i(int_n), .ext_i(ext_ind), .status_i(st), .rd_o(hrd));

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks=%0d mismatches=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Event and read pulses last one cycle; flags are checked a cycle on
  task automatic dp(input hcis_pkg::hcis_dev_s e);
    @(negedge clock_i) dev = e;
    @(negedge clock_i) dev = '0;
  endtask
  task automatic rp(input logic [4:0] r);
    @(negedge clock_i) drd = r;
    @(negedge clock_i) drd = '0;
  endtask
  task automatic bp(input int ch, input hcis_pkg::hcis_bev_s e, input logic [4:0] r);
    @(negedge clock_i) begin
      bev[ch] = e;
      brd[ch] = r;
    end
    @(negedge clock_i) begin
      bev[ch] = '0;
      brd[ch] = '0;
    end
  endtask

  task automatic t_rx;
    hcis_pkg::hcis_dev_s e;
    e = '0; e.rx_pool_full = 1'b1; dp(e);
    chk(st, 8'h40);
    chk(int_n, 1'b0);
    e = '0; e.ci_change = 1'b1; dp(e);
    rp(5'h10);
    chk(st, 8'h04);
    rp(5'h04);
    chk({st[7:1], int_n}, 8'h01);
    mask = 8'h84;
    e = '0; e.ci_change = 1'b1; e.rx_msg_end = 1'b1; e.rx_count = 5'h13; dp(e);
    chk({st[7:1], int_n}, 8'h05);
    chk(rbc, 8'h13);
    rp(5'h10);
    chk(pend, 8'h84);
    @(negedge clock_i) mask = 8'h00;
    @(negedge clock_i);
    chk({st[7:1], int_n}, 8'h84);
    rp(5'h14);
    chk(st, 8'h00);
    $display("test rx done");
  endtask

  task automatic t_ext;
    hcis_pkg::hcis_dev_s e;
    logic [3:0] exp [4] = '{4'h2, 4'h2, 4'h1, 4'h8};
    e = '0; e.tx_error = 1'b1; dp(e);
    chk({dex, 2'h0, ext_ind, int_n}, 8'h82);
    rp(5'h08);
    chk({dex, 2'h0, ext_ind, int_n}, 8'h01);
    ext_m = 1'b1;
    e = '0; e.tx_fifo_empty = 1'b1; dp(e);
    chk({dex, 2'h0, ext_ind, int_n}, 8'h41);
    rp(5'h08);
    e = '0; e.rx_bad_nr = 1'b1; dp(e);
    chk(dex, 8'h00);
    auto_m = 1'b1;
    for (int i = 0; i < 4; i++) begin
      e = '0;
      case (i)
        0: e.rx_bad_nr = 1'b1;
        1: e.rx_s_with_i = 1'b1;
        2: e.rx_frame_lost = 1'b1;
        default: e.tx_nak = 1'b1;
      endcase
      dp(e);
      chk(dex, exp[i]);
      rp(5'h08);
    end
    ext_m = 1'b0;
    $display("test ext done");
  endtask

  task automatic t_dst;
    hcis_pkg::hcis_dev_s e;
    logic [7:0] exp [8] = '{8'h20, 8'h00, 8'h10, 8'h10, 8'h08, 8'h08, 8'h00, 8'h01};
    for (int i = 0; i < 8; i++) begin
      e = '0;
      auto_m = (i != 1);
      case (i)
        0, 1: e.rx_rr_rnr = 1'b1;
        2: e.tx_pool_freed = 1'b1;
        3: e.tx_acked = 1'b1;
        4: e.ext_timer = 1'b1;
        5: {e.retransmission_timer_out, e.retry_counter_out} = 2'b11;
        6: e.retransmission_timer_out = 1'b1;
        default: e.timer2 = 1'b1;
      endcase
      dp(e);
      chk(st, exp[i]);
      rp(5'h10);
    end
    $display("test dst done");
  endtask

  task automatic t_b;
    hcis_pkg::hcis_bev_s e;
    for (int ch = 0; ch < 2; ch++) begin
      e = '0; e.transmitter_reset_cmd = 1'b1; bp(ch, e, 5'h00);
      chk({bpr, 5'h0, int_n}, 8'(8'h40 << ch));
      bmask[ch] = 1'b1;
      @(negedge clock_i) chk(int_n, 1'b1);
      bmask[ch] = 1'b0;
      e = '0; e.transparent_transmit_cmd = 1'b1; bp(ch, e, 5'h02);
      for (int k = 0; k < 2; k++) begin
        e = '0; e.pool_freed = 1'b1; bp(ch, e, 5'h00);
        chk(bpr, 8'(1 << ch));
        bp(ch, '0, 5'h02);
      end
      e = '0; e.end_of_message_cmd = 1'b1; bp(ch, e, 5'h00);
      e = '0; e.fcs_done = 1'b1; bp(ch, e, 5'h00);
      chk(bpr, 8'(1 << ch));
      e = '0; e.repeat_req = 1'b1; bp(ch, e, 5'h02);
      chk(bext, 8'(1 << 2 * ch));
      e = '0; e.transparent_transmit_cmd = 1'b1; bp(ch, e, 5'h01);
      e = '0; e.fifo_empty = 1'b1; bp(ch, e, 5'h00);
      chk(bext, 8'(2 << 2 * ch));
      e = '0; e.transmitter_reset_cmd = 1'b1; bp(ch, e, 5'h01);
      bp(ch, '0, 5'h02);
      chk({bpr, bext, int_n}, 8'h01);
    end
    $display("test b done");
  endtask

  task automatic t_host;
    hcis_pkg::hcis_dev_s e;
    host_en = 1'b1;
    e = '0; e.rx_pool_full = 1'b1; e.ci_change = 1'b1; dp(e);
    for (int i = 0; i < 10 && int_n !== 1'b1; i++) @(negedge clock_i);
    repeat (2) @(negedge clock_i);
    chk({st[7:1], int_n}, 8'h01);
    host_en = 1'b0;
    $display("test host done");
  endtask

  initial begin
    err_count = 0;
    n_checks = 0;
    reset_i = 1'b1;
    {auto_m, ext_m, host_en} = '0;
    {bev, dev, brd, drd, mask, bmask} = '0;
    repeat (6) @(negedge clock_i);
    reset_i = 1'b0;
    chk({st[7:1], int_n}, 8'h01);
    chk({dex, bext}, 8'h00);
    t_rx();
    t_ext();
    t_dst();
    t_b();
    t_host();
    results();
  end

  initial begin
    #(5.0 * 2000);
    err_count++;
    $display("watchdog expired");
    results();
  end
endmodule
`default_nettype wire
